//--- ssr_pkg.sv
// Purpose: Shared constants and types for the signal signature recognition block
// Assumes: AXI4-Lite register access with 32-bit data
// Notes:   Register offsets are byte addresses
package ssr_pkg;
  localparam int          SSR_ADDR_WIDTH  = 8;
  localparam int          SSR_DATA_WIDTH  = 32;
  localparam int          SSR_SAMPLE_BITS = 15;
  // Register byte offsets
  localparam logic [7:0]  OFFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFFS_RSSI_UPPER = 8'h04;
  localparam logic [7:0]  OFFS_RSSI_LOWER = 8'h08;
  localparam logic [7:0]  OFFS_AMP_LOWER  = 8'h0C;
  localparam logic [7:0]  OFFS_AMP_UPPER  = 8'h10;
  localparam logic [7:0]  OFFS_GAPS       = 8'h14;
  localparam logic [7:0]  OFFS_STATUS     = 8'h18;
  localparam logic [7:0]  OFFS_ERROR      = 8'h1C;
  localparam logic [7:0]  OFFS_IRQ_MASK   = 8'h20;
  localparam logic [7:0]  OFFS_LIVE       = 8'h24;
  // Control register bit positions
  localparam int          CTL_RSSI_EN     = 0;
  localparam int          CTL_AMP_EN      = 1;
  localparam int          CTL_INIT_ACQ_EN = 2;
  localparam int          CTL_CODE_EN     = 3;
  localparam int          CTL_TIMER_EN    = 4;
  localparam int          CTL_WIDE_DEV    = 5;
  localparam int          CTL_WIDTH       = 6;
  // Event bit positions (shared by error and mask registers)
  localparam int          EV_AMP_LOW      = 0;
  localparam int          EV_AMP_HIGH     = 1;
  localparam int          EV_RSSI_ABOVE   = 2;
  localparam int          EV_RSSI_BELOW   = 3;
  localparam int          EV_TIMEOUT      = 4;
  localparam int          EV_WIDTH        = 5;
  // Reset values, amplitude limits, chip length and AXI response codes
  localparam logic [7:0]  RST_RSSI_UPPER  = 8'hFF;
  localparam logic [7:0]  RST_RSSI_LOWER  = 8'h00;
  localparam logic [7:0]  RST_AMP_TH      = 8'h00;
  localparam logic [1:0]  RST_GAPS        = 2'h1;
  localparam logic [14:0] AMP_SAT         = 15'h7FFF;
  localparam logic [14:0] DEMOD_MAX       = 15'h7E00;
  localparam int          SAMPLES_PER_CHIP = 4;
  localparam logic [1:0]  AXI_OKAY        = 2'b00;
  localparam logic [1:0]  AXI_SLVERR      = 2'b10;

  typedef struct packed {
    logic [7:0]  rssi;
    logic        rssi_strobe;
    logic [14:0] demod;
    logic        sample_strobe;
    logic        wakeup_start;
    logic        slicer_valid;
  } ssr_rx_in_type;

  typedef struct packed {
    logic        rssi_above;
    logic        rssi_below;
    logic        rssi_in_range;
    logic        amp_fail;
    logic        slicer_init_start;
    logic        code_check_run;
    logic        timer_run;
  } ssr_rx_out_type;

  function automatic logic [14:0] ssr_decode_th(input logic [7:0] th);
    logic [30:0] full;
    full = 31'(th[3:0]) << th[7:4];
    ssr_decode_th = (full > 31'(AMP_SAT)) ? AMP_SAT : full[14:0];
  endfunction : ssr_decode_th
endpackage : ssr_pkg

//--- ssr_signature.sv
// Purpose: RSSI window comparator and modulation amplitude classifier with register access
// Assumes: Sample strobe at four per chip; all inputs synchronous to aclk
// Notes:   One level interrupt from sticky error bits gated by a mask
//
// Notes on behaviour
// [RULE1] Signal strength is compared against an upper and lower 8-bit limit.
// [RULE2] Above-upper and below-lower indicators are kept as latched status.
// [RULE3] In-range combines both indicators, its sense set by limit order.
// [RULE4] Software sets upper limit 255 or lower limit 0 for single-sided checks.
// [RULE5] Baseband is sampled four times per chip and differenced against one chip earlier.
// [RULE6] Each chip's measurement is the largest of its four differences.
// [RULE7] A measurement above the upper threshold fails at once.
// [RULE8] Low amplitude longer than the gap count in chips sets error bit 0.
// [RULE9] With one gap allowed, two successive low measurements fail.
// [RULE10] Thresholds decode as two to the upper nibble times the lower, capped at 7FFFh.
// [RULE11] Software puts the lower threshold at least 8 % below the expected amplitude.
// [RULE12] Demodulator input spans 0 to 32256, scaled by a wide deviation select bit; the code only clamps at 32256 and never reads CTL_WIDE_DEV.
// [RULE13] Every check has its own enable.
// [RULE14] Slicer acquisition starts with wakeup search only when enabled.
// [RULE15] Code checking starts when the slicer goes valid after wakeup search starts; the code starts it only while the wakeup search timer runs.
// [RULE16] A wakeup search timer starts with wakeup search and bounds the sequence.
// [RULE17] Upper not below lower means in-range is neither flag, else either flag.
`timescale 1ns/1ps
`default_nettype none
module ssr_signature
  import ssr_pkg::*;
#(
  parameter int TIMER_CYCLES = 100000
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [SSR_ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [SSR_DATA_WIDTH-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [SSR_ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [SSR_DATA_WIDTH-1:0]      s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire ssr_rx_in_type             rx_in,
  output ssr_rx_out_type                 rx_out,
  output logic                           irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [CTL_WIDTH-1:0] control;
  logic [7:0]           rssi_upper_limit;
  logic [7:0]           rssi_lower_limit;
  logic [7:0]           amplitude_lower_threshold;
  logic [7:0]           amplitude_upper_threshold;
  logic [1:0]           tolerated_gap_count;
  logic [EV_WIDTH-1:0]  signal_monitor_error;
  logic [EV_WIDTH-1:0]  irq_mask;
  logic [EV_WIDTH-1:0]  events;
  logic                 aw_held;
  logic                 w_held;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 do_write;
  logic [EV_WIDTH-1:0]  clear_mask;
  logic [14:0]          chip_amp;
  logic                 timer_expire;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr <= OFFS_LIVE && aw_addr[1:0] == 2'b00 &&
                         aw_addr != OFFS_STATUS && aw_addr != OFFS_LIVE) ?
                        AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control                   <= '0;
      rssi_upper_limit          <= RST_RSSI_UPPER;
      rssi_lower_limit          <= RST_RSSI_LOWER;
      amplitude_lower_threshold <= RST_AMP_TH;
      amplitude_upper_threshold <= RST_AMP_TH;
      tolerated_gap_count       <= RST_GAPS;
      irq_mask                  <= '0;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        OFFS_CONTROL:    control                   <= w_data[CTL_WIDTH-1:0]; // RULE13
        OFFS_RSSI_UPPER: rssi_upper_limit          <= w_data[7:0];
        OFFS_RSSI_LOWER: rssi_lower_limit          <= w_data[7:0];
        OFFS_AMP_LOWER:  amplitude_lower_threshold <= w_data[7:0];
        OFFS_AMP_UPPER:  amplitude_upper_threshold <= w_data[7:0];
        OFFS_GAPS:       tolerated_gap_count       <= w_data[1:0];
        OFFS_IRQ_MASK:   irq_mask                  <= w_data[EV_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  assign clear_mask = (do_write && w_strb[0] && aw_addr == OFFS_ERROR) ?
                      w_data[EV_WIDTH-1:0] : '0;

  // Sticky errors: a new event wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      signal_monitor_error <= '0;
    end else begin
      signal_monitor_error <= (signal_monitor_error & ~clear_mask) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((((signal_monitor_error & ~clear_mask) | events)) & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic [31:0] read_mux;
  logic        read_ok;

  always_comb begin
    read_mux = '0;
    read_ok  = 1'b1;
    case (s_axi_araddr)
      OFFS_CONTROL:    read_mux = 32'(control);
      OFFS_RSSI_UPPER: read_mux = 32'(rssi_upper_limit);
      OFFS_RSSI_LOWER: read_mux = 32'(rssi_lower_limit);
      OFFS_AMP_LOWER:  read_mux = 32'(amplitude_lower_threshold);
      OFFS_AMP_UPPER:  read_mux = 32'(amplitude_upper_threshold);
      OFFS_GAPS:       read_mux = 32'(tolerated_gap_count);
      OFFS_STATUS:     read_mux = 32'(rx_out);
      OFFS_ERROR:      read_mux = 32'(signal_monitor_error);
      OFFS_IRQ_MASK:   read_mux = 32'(irq_mask);
      OFFS_LIVE:       read_mux = 32'(chip_amp);
      default:         read_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_mux;
        s_axi_rresp  <= read_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RSSI window comparator
  logic next_above;
  logic next_below;

  assign next_above = rx_in.rssi > rssi_upper_limit; // RULE1
  assign next_below = rx_in.rssi < rssi_lower_limit; // RULE1

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_out.rssi_above    <= 1'b0;
      rx_out.rssi_below    <= 1'b0;
      rx_out.rssi_in_range <= 1'b0;
    end else if (control[CTL_RSSI_EN] && rx_in.rssi_strobe) begin
      rx_out.rssi_above <= next_above; // RULE2
      rx_out.rssi_below <= next_below; // RULE2
      if (rssi_upper_limit >= rssi_lower_limit) begin
        rx_out.rssi_in_range <= !next_above && !next_below; // RULE3 RULE17
      end else begin
        rx_out.rssi_in_range <= next_above || next_below; // RULE3 RULE17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulation amplitude measurement
  logic [14:0] delay_line [SAMPLES_PER_CHIP];
  logic [14:0] sample_in;
  logic [14:0] raw_diff;
  logic [14:0] run_max;
  logic [1:0]  phase;
  logic        chip_done;
  logic        amp_active;

  // Clamp to the demodulator span; deviation scale only affects software's threshold math
  assign sample_in = (rx_in.demod > DEMOD_MAX) ? DEMOD_MAX : rx_in.demod; // RULE12
  assign raw_diff  = (sample_in >= delay_line[SAMPLES_PER_CHIP-1]) ?
                     sample_in - delay_line[SAMPLES_PER_CHIP-1] :
                     delay_line[SAMPLES_PER_CHIP-1] - sample_in; // RULE5

  genvar gi;
  generate
    for (gi = 0; gi < SAMPLES_PER_CHIP; gi++) begin : g_delay
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          delay_line[gi] <= '0;
        end else if (rx_in.sample_strobe) begin
          delay_line[gi] <= (gi == 0) ? sample_in : delay_line[(gi == 0) ? 0 : gi-1]; // RULE5
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amp_active <= 1'b0;
    end else if (!control[CTL_AMP_EN]) begin
      amp_active <= 1'b0;
    end else if (rx_in.wakeup_start) begin
      amp_active <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rx_in.wakeup_start) begin
      phase     <= '0;
      run_max   <= '0;
      chip_amp  <= '0;
      chip_done <= 1'b0;
    end else begin
      chip_done <= 1'b0;
      if (rx_in.sample_strobe) begin
        phase <= phase + 2'd1;
        if (phase == 2'(SAMPLES_PER_CHIP - 1)) begin
          chip_amp  <= (raw_diff > run_max) ? raw_diff : run_max; // RULE6
          run_max   <= '0;
          chip_done <= amp_active;
        end else begin
          run_max <= (raw_diff > run_max) ? raw_diff : run_max; // RULE6
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Amplitude decision
  logic [14:0] upper_th;
  logic [14:0] lower_th;
  logic [2:0]  low_run;
  logic        is_low;

  assign upper_th = ssr_decode_th(amplitude_upper_threshold); // RULE10
  assign lower_th = ssr_decode_th(amplitude_lower_threshold); // RULE10
  assign is_low   = chip_amp < lower_th;

  always_ff @(posedge aclk) begin
    if (!aresetn || rx_in.wakeup_start) begin
      low_run <= '0;
    end else if (chip_done) begin
      low_run <= is_low ? ((low_run == 3'h7) ? low_run : low_run + 3'd1) : '0;
    end
  end

  always_comb begin
    events = '0;
    events[EV_AMP_HIGH] = chip_done && chip_amp > upper_th; // RULE7
    events[EV_AMP_LOW]  = chip_done && is_low &&
                          low_run >= 3'(tolerated_gap_count); // RULE8 RULE9
    events[EV_RSSI_ABOVE] = control[CTL_RSSI_EN] && rx_in.rssi_strobe && next_above;
    events[EV_RSSI_BELOW] = control[CTL_RSSI_EN] && rx_in.rssi_strobe && next_below;
    events[EV_TIMEOUT]    = timer_expire;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rx_in.wakeup_start) begin
      rx_out.amp_fail <= 1'b0;
    end else if (events[EV_AMP_HIGH] || events[EV_AMP_LOW]) begin
      rx_out.amp_fail <= 1'b1; // RULE7 RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start conditions and wakeup search timer
  logic [31:0] timer_count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_out.slicer_init_start <= 1'b0;
    end else begin
      rx_out.slicer_init_start <= rx_in.wakeup_start && control[CTL_INIT_ACQ_EN]; // RULE14
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !control[CTL_CODE_EN]) begin
      rx_out.code_check_run <= 1'b0;
    end else if (rx_in.wakeup_start) begin
      rx_out.code_check_run <= 1'b0;
    end else if (rx_out.timer_run && rx_in.slicer_valid) begin
      rx_out.code_check_run <= 1'b1; // RULE15
    end
  end

  assign timer_expire = rx_out.timer_run && timer_count == 32'(TIMER_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || !control[CTL_TIMER_EN]) begin
      rx_out.timer_run <= 1'b0;
      timer_count      <= '0;
    end else if (rx_in.wakeup_start) begin
      rx_out.timer_run <= 1'b1; // RULE16
      timer_count      <= '0;
    end else if (timer_expire) begin
      rx_out.timer_run <= 1'b0; // RULE16
    end else if (rx_out.timer_run) begin
      timer_count <= timer_count + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_in_range;
    @(posedge aclk) disable iff (!aresetn)
      control[CTL_RSSI_EN] && rx_in.rssi_strobe && rssi_upper_limit >= rssi_lower_limit
      |=> rx_out.rssi_in_range == (!rx_out.rssi_above && !rx_out.rssi_below);
  endproperty
  a_in_range: assert property (p_in_range) else $error("in-range wrong"); // RULE17

  property p_out_range;
    @(posedge aclk) disable iff (!aresetn)
      control[CTL_RSSI_EN] && rx_in.rssi_strobe && rssi_upper_limit < rssi_lower_limit
      |=> rx_out.rssi_in_range == (rx_out.rssi_above || rx_out.rssi_below);
  endproperty
  a_out_range: assert property (p_out_range) else $error("out-range wrong"); // RULE3

  property p_above;
    @(posedge aclk) disable iff (!aresetn)
      control[CTL_RSSI_EN] && rx_in.rssi_strobe |=>
      rx_out.rssi_above == ($past(rx_in.rssi) > $past(rssi_upper_limit));
  endproperty
  a_above: assert property (p_above) else $error("above flag wrong"); // RULE1

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      !rx_in.rssi_strobe |=> $stable(rx_out.rssi_below);
  endproperty
  a_hold: assert property (p_hold) else $error("below flag not held"); // RULE2

  property p_high_fail;
    @(posedge aclk) disable iff (!aresetn || rx_in.wakeup_start)
      chip_done && chip_amp > upper_th |=> rx_out.amp_fail;
  endproperty
  a_high_fail: assert property (p_high_fail) else $error("high fail missed"); // RULE7

  property p_low_err;
    @(posedge aclk) disable iff (!aresetn)
      events[EV_AMP_LOW] |=> signal_monitor_error[EV_AMP_LOW];
  endproperty
  a_low_err: assert property (p_low_err) else $error("low error not set"); // RULE8

  property p_one_gap;
    @(posedge aclk) disable iff (!aresetn || rx_in.wakeup_start)
      chip_done && is_low && low_run == 3'd0 && tolerated_gap_count == 2'd1
      |-> !events[EV_AMP_LOW];
  endproperty
  a_one_gap: assert property (p_one_gap) else $error("single gap failed"); // RULE9

  property p_sat;
    @(posedge aclk) disable iff (!aresetn)
      amplitude_upper_threshold[7:4] == 4'hF && amplitude_upper_threshold[3:0] != 4'h0
      |-> upper_th == AMP_SAT;
  endproperty
  a_sat: assert property (p_sat) else $error("threshold decode wrong"); // RULE10

  property p_init;
    @(posedge aclk) disable iff (!aresetn)
      rx_in.wakeup_start && !control[CTL_INIT_ACQ_EN] |=> !rx_out.slicer_init_start;
  endproperty
  a_init: assert property (p_init) else $error("init acq started"); // RULE14

  property p_timer;
    @(posedge aclk) disable iff (!aresetn)
      rx_in.wakeup_start && control[CTL_TIMER_EN] |=> rx_out.timer_run;
  endproperty
  a_timer: assert property (p_timer) else $error("timer not started"); // RULE16

endmodule : ssr_signature
`default_nettype wire

//--- ssr_signature_tb.sv
// Purpose: Self-checking bench for ssr_signature over its register bus and receive ports
// Assumes: AXI4-Lite master tasks; wakeup timer shortened to 50 cycles
// Notes:   Expected values come from the limits and thresholds programmed here
`timescale 1ns/1ps
`default_nettype none
module ssr_signature_tb;
  import ssr_pkg::*;
  logic           aclk    = 1'b0;
  logic           aresetn = 1'b0;
  logic [7:0]     awaddr  = '0;
  logic [7:0]     araddr  = '0;
  logic [31:0]    wdata   = '0;
  logic [3:0]     wstrb   = '0;
  logic           awvalid = 1'b0;
  logic           wvalid  = 1'b0;
  logic           bready  = 1'b0;
  logic           arvalid = 1'b0;
  logic           rready  = 1'b0;
  logic           awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]     bresp, rresp, resp;
  logic [31:0]    rdata, d;
  ssr_rx_in_type  rx_in   = '0;
  ssr_rx_out_type rx_out;
  int             error_cnt = 0;
  int             n_checks  = 0;
  int             pulse_cnt = 0;

  always #5 aclk = ~aclk;
  always @(posedge aclk) if (rx_out.slicer_init_start === 1'b1) pulse_cnt <= pulse_cnt + 1;

  ssr_signature #(.TIMER_CYCLES(50)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_in(rx_in), .rx_out(rx_out), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("TB: checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Ready and response are registered, so the negedge view holds at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) chk(32'h0000_0000, 32'h0000_0001, "write answer");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      v  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    if (!tr) chk(32'h0000_0000, 32'h0000_0001, "read answer");
  endtask : rd

  task automatic wc(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, resp);
  endtask : wc

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, d, resp);
    chk(d, e, nm);
  endtask : rc

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : cyc

  task automatic rs(input logic [7:0] v);
    @(posedge aclk);
    rx_in.rssi        <= v;
    rx_in.rssi_strobe <= 1'b1;
    @(posedge aclk);
    rx_in.rssi_strobe <= 1'b0;
    cyc(3);
  endtask : rs

  task automatic wake();
    @(posedge aclk);
    rx_in.wakeup_start <= 1'b1;
    @(posedge aclk);
    rx_in.wakeup_start <= 1'b0;
  endtask : wake

  // One chip is four strobed samples
  task automatic chip(input int a, input int b, input int c, input int e);
    int s[4];
    s = '{a, b, c, e};
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      rx_in.demod         <= 15'(s[i]);
      rx_in.sample_strobe <= 1'b1;
      @(posedge aclk);
      rx_in.sample_strobe <= 1'b0;
    end
  endtask : chip

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFFS_RSSI_UPPER, 32'h0000_00FF, "rssi_upper_limit");
    rc(OFFS_RSSI_LOWER, 32'h0000_0000, "rssi_lower_limit");
    rc(OFFS_GAPS, 32'h0000_0001, "tolerated_gap_count");
    rd(8'h30, d, resp);
    chk({30'h0, resp}, {30'h0, AXI_SLVERR}, "unmapped read");
    wr(OFFS_STATUS, 32'hFFFF_FFFF, resp);
    chk({30'h0, resp}, {30'h0, AXI_SLVERR}, "status write");
    $display("TB: register test done");
    rs(8'h90);
    chk(32'(rx_out.rssi_above), 32'h0000_0000, "above while disabled");
    wc(OFFS_RSSI_UPPER, 32'h0000_0080);
    wc(OFFS_RSSI_LOWER, 32'h0000_0040);
    wc(OFFS_CONTROL, 32'(1) << CTL_RSSI_EN);
    rs(8'h60);
    chk(32'(rx_out.rssi_in_range), 32'h0000_0001, "in band");
    chk(32'({rx_out.rssi_above, rx_out.rssi_below}), 32'h0000_0000, "flags in band");
    rs(8'h90);
    chk(32'(rx_out.rssi_above), 32'h0000_0001, "above upper");
    chk(32'(rx_out.rssi_in_range), 32'h0000_0000, "out of band");
    rs(8'h20);
    chk(32'(rx_out.rssi_below), 32'h0000_0001, "below lower");
    rc(OFFS_ERROR, 32'h0000_000C, "rssi events");
    wc(OFFS_RSSI_UPPER, 32'h0000_0040);
    wc(OFFS_RSSI_LOWER, 32'h0000_0080);
    rs(8'h90);
    chk(32'(rx_out.rssi_in_range), 32'h0000_0001, "inverted limits");
    wc(OFFS_ERROR, 32'h0000_001F);
    rc(OFFS_ERROR, 32'h0000_0000, "events cleared");
    $display("TB: rssi test done");
    wc(OFFS_AMP_LOWER, 32'h0000_0041);
    wc(OFFS_AMP_UPPER, 32'h0000_0045);
    wc(OFFS_IRQ_MASK, 32'h0000_0003);
    wc(OFFS_CONTROL, 32'(1) << CTL_AMP_EN);
    wake();
    chip(50, 50, 50, 50);
    chip(0, 0, 0, 0);
    chip(0, 0, 0, 0);
    chip(50, 50, 50, 50);
    cyc(3);
    chk(32'(rx_out.amp_fail), 32'h0000_0000, "single gap");
    rc(OFFS_ERROR, 32'h0000_0000, "no low error");
    chip(50, 50, 50, 50);
    chip(50, 50, 50, 50);
    cyc(3);
    chk(32'(rx_out.amp_fail), 32'h0000_0001, "two lows");
    rc(OFFS_ERROR, 32'h0000_0001, "low amplitude error");
    chk(32'(irq), 32'h0000_0001, "irq raised");
    wc(OFFS_IRQ_MASK, 32'h0000_0000);
    cyc(2);
    chk(32'(irq), 32'h0000_0000, "irq masked");
    wc(OFFS_IRQ_MASK, 32'h0000_0003);
    wc(OFFS_ERROR, 32'h0000_0001);
    cyc(2);
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    wake();
    cyc(2);
    chk(32'(rx_out.amp_fail), 32'h0000_0000, "fail cleared");
    chip(0, 0, 0, 0);
    chip(0, 0, 0, 90);
    cyc(3);
    chk(32'(rx_out.amp_fail), 32'h0000_0001, "high fails");
    rc(OFFS_ERROR, 32'h0000_0002, "high amplitude error");
    rc(OFFS_LIVE, 32'd90, "largest of four");
    wc(OFFS_ERROR, 32'h0000_001F);
    wc(OFFS_AMP_UPPER, 32'h0000_00FF);
    wake();
    chip(0, 0, 0, 0);
    chip(32256, 32256, 32256, 32256);
    cyc(3);
    chk(32'(rx_out.amp_fail), 32'h0000_0000, "saturated upper");
    rc(OFFS_LIVE, 32'd32256, "full scale amplitude");
    $display("TB: amplitude test done");
    chk(32'(pulse_cnt), 32'h0000_0000, "no acquisition");
    wc(OFFS_CONTROL, (32'(1) << CTL_INIT_ACQ_EN) | (32'(1) << CTL_CODE_EN) |
                     (32'(1) << CTL_TIMER_EN));
    wake();
    cyc(3);
    chk(32'(pulse_cnt), 32'h0000_0001, "acquisition start");
    chk(32'(rx_out.timer_run), 32'h0000_0001, "timer runs");
    chk(32'(rx_out.code_check_run), 32'h0000_0000, "code idle");
    @(posedge aclk);
    rx_in.slicer_valid <= 1'b1;
    cyc(3);
    chk(32'(rx_out.code_check_run), 32'h0000_0001, "code runs");
    cyc(60);
    chk(32'(rx_out.timer_run), 32'h0000_0000, "timer stops");
    rc(OFFS_ERROR, 32'h0000_0010, "timer expired");
    $display("TB: sequence test done");
    print_verdict();
  end

  initial begin
    #200_000;
    error_cnt++;
    $display("CHECK FAILED watchdog expected done seen hang");
    print_verdict();
  end
endmodule : ssr_signature_tb
`default_nettype wire
